// ---- ebtcp_pkg.sv ----
// shared constants, types and helpers of the eight-bit compare/pwm timer
package ebtcp_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned PRESC_W = 10;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_COUNTER = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CMP_A = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_CMP_B = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_INT_EN = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_ASYNC = 3'h7;

    // field positions
    localparam int unsigned CTRLA_COMA_LSB = 6;
    localparam int unsigned CTRLA_COMB_LSB = 4;
    localparam int unsigned CTRLA_WGM_LSB = 0;
    localparam int unsigned CTRLB_FORCE_A_BIT = 7;
    localparam int unsigned CTRLB_FORCE_B_BIT = 6;
    localparam int unsigned CTRLB_WGM2_BIT = 3;
    localparam int unsigned CTRLB_CS_LSB = 0;
    localparam int unsigned FLAG_OVF_BIT = 0;
    localparam int unsigned FLAG_CMPA_BIT = 1;
    localparam int unsigned FLAG_CMPB_BIT = 2;
    localparam int unsigned ASYNC_SEL_BIT = 0;

    // reset values
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam logic [2:0] RST_CS = 3'h0;

    // count landmarks
    localparam logic [DATA_W-1:0] CNT_BOTTOM = 8'h00;
    localparam logic [DATA_W-1:0] CNT_MAX = 8'hff;
    localparam logic [DATA_W-1:0] CNT_STEP = 8'h01;

    // clock select code that stops the timer
    localparam logic [2:0] CS_STOPPED = 3'h0;

    typedef enum logic [2:0] {
        WGM_NORMAL = 3'h0,
        WGM_PC_MAX = 3'h1,
        WGM_CTC = 3'h2,
        WGM_FAST_MAX = 3'h3,
        WGM_RSV4 = 3'h4,
        WGM_PC_CMP = 3'h5,
        WGM_RSV6 = 3'h6,
        WGM_FAST_CMP = 3'h7
    } ebtcp_wgm_t;

    typedef enum logic [1:0] {
        COM_OFF = 2'h0,
        COM_TOGGLE = 2'h1,
        COM_CLEAR = 2'h2,
        COM_SET = 2'h3
    } ebtcp_com_t;

    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } ebtcp_dir_t;

    function automatic logic is_fast(input ebtcp_wgm_t wgm);
        return (wgm == WGM_FAST_MAX) || (wgm == WGM_FAST_CMP);
    endfunction : is_fast

    function automatic logic is_phase(input ebtcp_wgm_t wgm);
        return (wgm == WGM_PC_MAX) || (wgm == WGM_PC_CMP);
    endfunction : is_phase

    function automatic logic is_pwm(input ebtcp_wgm_t wgm);
        return is_fast(wgm) || is_phase(wgm);
    endfunction : is_pwm

endpackage : ebtcp_pkg

// ---- ebtcp_tick_gen.sv ----
// timer tick source: clock select, oscillator pin sync and prescaler
`timescale 1ns/100ps
module ebtcp_tick_gen
    import ebtcp_pkg::*;
#(
    parameter int unsigned PW = PRESC_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // selection
    input wire logic asyncClockSelect,
    input wire logic [2:0] clockSelectField,
    // oscillator pins
    input wire logic oscillatorPinOne,
    output logic oscillatorPinTwo,
    // tick
    output logic timerTick
);

    typedef struct packed {
        logic oscSync1;
        logic oscSync2;
        logic oscPrev;
        logic [PW-1:0] presc;
        logic tick;
    } ebtcp_tick_state_t;

    ebtcp_tick_state_t stateReg;
    ebtcp_tick_state_t stateNext;

    // divisor mask per clock select code: 1, 8, 32, 64, 128, 256, 1024
    function automatic logic [PW-1:0] tap_mask(input logic [2:0] cs);
        case (cs)
            3'h1: return PW'(0);
            3'h2: return PW'(7);
            3'h3: return PW'(31);
            3'h4: return PW'(63);
            3'h5: return PW'(127);
            3'h6: return PW'(255);
            default: return PW'(1023);
        endcase
    endfunction : tap_mask

    logic srcEdge;

    always_comb begin
        stateNext = stateReg;
        stateNext.oscSync1 = oscillatorPinOne;
        stateNext.oscSync2 = stateReg.oscSync1;
        stateNext.oscPrev = stateReg.oscSync2;
        // io clock by default, crystal edge when async selected
        srcEdge = asyncClockSelect ? (stateReg.oscSync2 & ~stateReg.oscPrev) : 1'b1;
        stateNext.tick = 1'b0;
        if (clockSelectField == CS_STOPPED) begin
            stateNext.presc = '0;
        end else if (srcEdge) begin
            stateNext.presc = stateReg.presc + PW'(1);
            stateNext.tick = ((stateReg.presc & tap_mask(clockSelectField)) == '0);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign timerTick = stateReg.tick;
    assign oscillatorPinTwo = ~stateReg.oscSync2;

endmodule : ebtcp_tick_gen

// ---- ebtcp_compare_out.sv ----
// one compare output channel: output state, waveform actions, port override
`timescale 1ns/100ps
module ebtcp_compare_out
    import ebtcp_pkg::*;
#(
    parameter logic TOGGLE_IN_PWM = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // events from the counter
    input wire logic timerTick,
    input wire logic compareMatch,
    input wire logic wrapToBottom,
    input wire logic forceCompareStrobe,
    // configuration
    input wire ebtcp_wgm_t waveformMode,
    input wire ebtcp_com_t compareOutputMode,
    // port
    input wire logic portData,
    input wire logic outputPinDirectionBit,
    output logic compareOutputState,
    output logic pinOut,
    output logic pinOe
);

    typedef struct packed {
        logic oc;
    } ebtcp_oc_state_t;

    ebtcp_oc_state_t stateReg;
    ebtcp_oc_state_t stateNext;

    function automatic logic apply_com(input ebtcp_com_t com, input logic cur);
        case (com)
            COM_TOGGLE: return ~cur;
            COM_CLEAR: return 1'b0;
            COM_SET: return 1'b1;
            default: return cur;
        endcase
    endfunction : apply_com

    always_comb begin
        stateNext = stateReg;
        if (!is_pwm(waveformMode)) begin
            // forced action needs no real match, pin need not be enabled
            if ((timerTick && compareMatch) || forceCompareStrobe) begin
                stateNext.oc = apply_com(compareOutputMode, stateReg.oc);
            end
        end else if (is_fast(waveformMode)) begin
            if (timerTick && wrapToBottom) begin
                if (compareOutputMode == COM_CLEAR) begin
                    stateNext.oc = 1'b1;
                end else if (compareOutputMode == COM_SET) begin
                    stateNext.oc = 1'b0;
                end
            end else if (timerTick && compareMatch) begin
                if (compareOutputMode == COM_TOGGLE) begin
                    if (TOGGLE_IN_PWM && waveformMode[2]) begin
                        stateNext.oc = ~stateReg.oc;
                    end
                end else begin
                    stateNext.oc = apply_com(compareOutputMode, stateReg.oc);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign compareOutputState = stateReg.oc;
    // mode bits act at once, override in every waveform mode
    assign pinOut = (compareOutputMode != COM_OFF) ? stateReg.oc : portData;
    assign pinOe = outputPinDirectionBit;

endmodule : ebtcp_compare_out

// ---- ebtcp_timer.sv ----
// eight-bit timer/counter with two compare channels and fast pwm
//
// Operation
// - tick from io clock, crystal when selected
// - each tick clears, increments or decrements counter
// - clock select zero stops all ticks
// - counter readable and writable at any time
// - processor write beats hardware clear or count
// - three-bit waveform mode split over two registers
// - compare always; flag set on next tick
// - enabled flag requests interrupt; service or one clears
// - output mode bits act immediately, unbuffered
// - nonzero mode overrides port; direction bit still gates
// - output state settable before pin enabled
// - mode zero leaves output state unchanged
// - force strobe applies action in non-pwm modes
// - mode 0 counts up, wraps ff to 00
// - mode 0 overflow flag set when counter zeroes
// - mode 2 clears counter on compare a
// - mode 2 compare a unbuffered, late match wraps
// - mode 2 toggle output a on match
// - mode 2 overflow flag on max to zero
// - modes 3 and 7 count up to top
// - fast pwm clear on match, set at bottom
// - fast pwm clears counter tick after top
// - fast pwm overflow flag on the tick that wraps top to bottom
// - bottom is zero, maximum is ff
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module ebtcp_timer
    import ebtcp_pkg::*;
#(
    parameter int unsigned PW = PRESC_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdata,
    // interrupt requests and service acknowledges
    output logic irqOverflow,
    output logic irqCompareA,
    output logic irqCompareB,
    input wire logic ackOverflow,
    input wire logic ackCompareA,
    input wire logic ackCompareB,
    // oscillator pins
    input wire logic oscillatorPinOne,
    output logic oscillatorPinTwo,
    // channel a pin
    input wire logic portDataA,
    input wire logic outputPinDirectionBitA,
    output logic compareOutputA,
    output logic compareOutputAOe,
    // channel b pin
    input wire logic portDataB,
    input wire logic outputPinDirectionBitB,
    output logic compareOutputB,
    output logic compareOutputBOe
);

    typedef struct packed {
        logic [DATA_W-1:0] controlRegisterA;
        logic waveformModeBit2;
        logic [2:0] clockSelectField;
        logic asyncClockSelect;
        logic [DATA_W-1:0] counterValue;
        logic [DATA_W-1:0] compareValueA;
        logic [DATA_W-1:0] compareValueB;
        logic [DATA_W-1:0] activeCompareA;
        logic [DATA_W-1:0] activeCompareB;
        logic overflowFlag;
        logic compareFlagA;
        logic compareFlagB;
        logic [2:0] intEnable;
        ebtcp_dir_t direction;
        logic forceA;
        logic forceB;
        logic [DATA_W-1:0] rdata;
    } ebtcp_state_t;

    ebtcp_state_t stateReg;
    ebtcp_state_t stateNext;

    logic timerTick;
    ebtcp_wgm_t waveformMode;
    ebtcp_com_t compareOutputModeA;
    ebtcp_com_t compareOutputModeB;
    logic [DATA_W-1:0] topValue;
    logic matchA;
    logic matchB;
    logic atTop;
    logic wrapToBottom;
    logic pwmMatchA;
    logic pwmMatchB;
    logic setOverflow;
    logic wrCtrlA;
    logic wrCtrlB;
    logic wrFlags;
    logic [DATA_W-1:0] cnt;

    function automatic logic [DATA_W-1:0] cnt_inc(input logic [DATA_W-1:0] v);
        return v + CNT_STEP;
    endfunction : cnt_inc

    function automatic logic [DATA_W-1:0] cnt_dec(input logic [DATA_W-1:0] v);
        return v - CNT_STEP;
    endfunction : cnt_dec

    // waveform mode from both control registers
    assign waveformMode = ebtcp_wgm_t'({stateReg.waveformModeBit2,
        stateReg.controlRegisterA[CTRLA_WGM_LSB +: 2]});
    assign compareOutputModeA = ebtcp_com_t'(stateReg.controlRegisterA[CTRLA_COMA_LSB +: 2]);
    assign compareOutputModeB = ebtcp_com_t'(stateReg.controlRegisterA[CTRLA_COMB_LSB +: 2]);

    // top is max or compare a depending on mode
    assign topValue = ((waveformMode == WGM_FAST_CMP) || (waveformMode == WGM_PC_CMP)) ?
        stateReg.activeCompareA : CNT_MAX;

    // continuous comparators
    assign matchA = (stateReg.counterValue == stateReg.activeCompareA);
    assign matchB = (stateReg.counterValue == stateReg.activeCompareB);
    assign atTop = (stateReg.counterValue == topValue);
    assign wrapToBottom = is_fast(waveformMode) && atTop;

    // in fast pwm, match at top ignored when mode bit 1 set
    assign pwmMatchA = matchA && !(is_fast(waveformMode) && (stateReg.activeCompareA == topValue)
        && compareOutputModeA[1]);
    assign pwmMatchB = matchB && !(is_fast(waveformMode) && (stateReg.activeCompareB == topValue)
        && compareOutputModeB[1]);

    assign wrCtrlA = regWrite && (regAddr == ADDR_CTRL_A);
    assign wrCtrlB = regWrite && (regAddr == ADDR_CTRL_B);
    assign wrFlags = regWrite && (regAddr == ADDR_FLAGS);

    always_comb begin
        stateNext = stateReg;
        setOverflow = 1'b0;
        cnt = stateReg.counterValue;
        stateNext.forceA = 1'b0;
        stateNext.forceB = 1'b0;

        // counting sequence per waveform mode on each tick
        if (timerTick) begin
            case (waveformMode)
                WGM_CTC: begin
                    if (matchA) begin
                        cnt = CNT_BOTTOM;
                    end else begin
                        cnt = cnt_inc(stateReg.counterValue);
                    end
                    setOverflow = (stateReg.counterValue == CNT_MAX);
                end
                WGM_FAST_MAX, WGM_FAST_CMP: begin
                    if (atTop) begin
                        cnt = CNT_BOTTOM;
                        setOverflow = 1'b1;
                        stateNext.activeCompareA = stateReg.compareValueA;
                        stateNext.activeCompareB = stateReg.compareValueB;
                    end else begin
                        cnt = cnt_inc(stateReg.counterValue);
                    end
                end
                WGM_PC_MAX, WGM_PC_CMP: begin
                    if (stateReg.direction == DIR_UP) begin
                        if (atTop) begin
                            stateNext.direction = DIR_DOWN;
                            cnt = cnt_dec(stateReg.counterValue);
                            stateNext.activeCompareA = stateReg.compareValueA;
                            stateNext.activeCompareB = stateReg.compareValueB;
                        end else begin
                            cnt = cnt_inc(stateReg.counterValue);
                        end
                    end else begin
                        if (stateReg.counterValue == CNT_BOTTOM) begin
                            stateNext.direction = DIR_UP;
                            cnt = cnt_inc(stateReg.counterValue);
                            setOverflow = 1'b1;
                        end else begin
                            cnt = cnt_dec(stateReg.counterValue);
                        end
                    end
                end
                default: begin
                    // normal and reserved modes: free count, wrap ff to 00
                    cnt = cnt_inc(stateReg.counterValue);
                    setOverflow = (stateReg.counterValue == CNT_MAX);
                end
            endcase
        end
        if (!is_phase(waveformMode)) begin
            stateNext.direction = DIR_UP;
        end

        // processor write to the counter wins over hardware
        if (regWrite && (regAddr == ADDR_COUNTER)) begin
            stateNext.counterValue = regWdata;
        end else begin
            stateNext.counterValue = cnt;
        end

        // control and configuration registers
        if (wrCtrlA) begin
            stateNext.controlRegisterA = regWdata & 8'hf3;
        end
        if (wrCtrlB) begin
            stateNext.waveformModeBit2 = regWdata[CTRLB_WGM2_BIT];
            stateNext.clockSelectField = regWdata[CTRLB_CS_LSB +: 3];
            // force strobes only act outside pwm
            stateNext.forceA = regWdata[CTRLB_FORCE_A_BIT] && !is_pwm(waveformMode);
            stateNext.forceB = regWdata[CTRLB_FORCE_B_BIT] && !is_pwm(waveformMode);
        end
        if (regWrite && (regAddr == ADDR_ASYNC)) begin
            stateNext.asyncClockSelect = regWdata[ASYNC_SEL_BIT];
        end
        if (regWrite && (regAddr == ADDR_INT_EN)) begin
            stateNext.intEnable = regWdata[2:0];
        end

        // compare values: direct outside pwm, buffered until top inside
        if (regWrite && (regAddr == ADDR_CMP_A)) begin
            stateNext.compareValueA = regWdata;
            if (!is_pwm(waveformMode)) begin
                stateNext.activeCompareA = regWdata;
            end
        end
        if (regWrite && (regAddr == ADDR_CMP_B)) begin
            stateNext.compareValueB = regWdata;
            if (!is_pwm(waveformMode)) begin
                stateNext.activeCompareB = regWdata;
            end
        end

        // flags: set beats service or write-one clear
        stateNext.overflowFlag = (stateReg.overflowFlag
            & ~(ackOverflow | (wrFlags & regWdata[FLAG_OVF_BIT]))) | setOverflow;
        stateNext.compareFlagA = (stateReg.compareFlagA
            & ~(ackCompareA | (wrFlags & regWdata[FLAG_CMPA_BIT])))
            | (timerTick & matchA);
        stateNext.compareFlagB = (stateReg.compareFlagB
            & ~(ackCompareB | (wrFlags & regWdata[FLAG_CMPB_BIT])))
            | (timerTick & matchB);

        // read data stand only in the cycle after the strobe
        stateNext.rdata = RST_BYTE;
        if (regRead) begin
            case (regAddr)
                ADDR_CTRL_A: stateNext.rdata = stateReg.controlRegisterA;
                ADDR_CTRL_B: stateNext.rdata = {4'h0, stateReg.waveformModeBit2,
                    stateReg.clockSelectField};
                ADDR_COUNTER: stateNext.rdata = stateReg.counterValue;
                ADDR_CMP_A: stateNext.rdata = stateReg.compareValueA;
                ADDR_CMP_B: stateNext.rdata = stateReg.compareValueB;
                ADDR_FLAGS: stateNext.rdata = {5'h00, stateReg.compareFlagB,
                    stateReg.compareFlagA, stateReg.overflowFlag};
                ADDR_INT_EN: stateNext.rdata = {5'h00, stateReg.intEnable};
                ADDR_ASYNC: stateNext.rdata = {7'h00, stateReg.asyncClockSelect};
                default: stateNext.rdata = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stateReg <= '0;
            stateReg.clockSelectField <= RST_CS;
            stateReg.controlRegisterA <= RST_BYTE;
            stateReg.counterValue <= RST_BYTE;
            stateReg.direction <= DIR_UP;
        end else begin
            stateReg <= stateNext;
        end
    end

    ebtcp_tick_gen #(
        .PW(PW)
    ) u_tick (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .asyncClockSelect(stateReg.asyncClockSelect),
        .clockSelectField(stateReg.clockSelectField),
        .oscillatorPinOne(oscillatorPinOne),
        .oscillatorPinTwo(oscillatorPinTwo),
        .timerTick(timerTick)
    );

    ebtcp_compare_out #(
        .TOGGLE_IN_PWM(1'b1)
    ) u_out_a (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .timerTick(timerTick),
        .compareMatch(pwmMatchA),
        .wrapToBottom(wrapToBottom),
        .forceCompareStrobe(stateReg.forceA),
        .waveformMode(waveformMode),
        .compareOutputMode(compareOutputModeA),
        .portData(portDataA),
        .outputPinDirectionBit(outputPinDirectionBitA),
        .compareOutputState(),
        .pinOut(compareOutputA),
        .pinOe(compareOutputAOe)
    );

    ebtcp_compare_out #(
        .TOGGLE_IN_PWM(1'b0)
    ) u_out_b (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .timerTick(timerTick),
        .compareMatch(pwmMatchB),
        .wrapToBottom(wrapToBottom),
        .forceCompareStrobe(stateReg.forceB),
        .waveformMode(waveformMode),
        .compareOutputMode(compareOutputModeB),
        .portData(portDataB),
        .outputPinDirectionBit(outputPinDirectionBitB),
        .compareOutputState(),
        .pinOut(compareOutputB),
        .pinOe(compareOutputBOe)
    );

    // interrupt requests from enabled flags
    assign irqOverflow = stateReg.overflowFlag & stateReg.intEnable[FLAG_OVF_BIT];
    assign irqCompareA = stateReg.compareFlagA & stateReg.intEnable[FLAG_CMPA_BIT];
    assign irqCompareB = stateReg.compareFlagB & stateReg.intEnable[FLAG_CMPB_BIT];
    assign regRdata = stateReg.rdata;

endmodule : ebtcp_timer

// ---- ebtcp_timer_chk.sv ----
// port checker of the eight-bit compare/pwm timer
`timescale 1ns/100ps
module ebtcp_timer_chk
    import ebtcp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [DATA_W-1:0] regRdata,
    input wire logic irqOverflow,
    // pins
    input wire logic portDataA,
    input wire logic portDataB,
    input wire logic outputPinDirectionBitA,
    input wire logic outputPinDirectionBitB,
    input wire logic compareOutputA,
    input wire logic compareOutputB,
    input wire logic compareOutputAOe,
    input wire logic compareOutputBOe
);
    typedef struct packed {
        logic [7:0] ctrlA;
        logic ovfEn;
    } ebtcp_chk_t;
    ebtcp_chk_t s_reg;
    ebtcp_chk_t s_next;
    logic forceA;
    always_comb begin
        s_next = s_reg;
        if (regWrite && regAddr == ADDR_CTRL_A)
            s_next.ctrlA = regWdata;
        if (regWrite && regAddr == ADDR_INT_EN)
            s_next.ovfEn = regWdata[FLAG_OVF_BIT];
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
    // force a, non-pwm, set or clear
    assign forceA = regWrite && regAddr == ADDR_CTRL_B && regWdata[CTRLB_FORCE_A_BIT]
        && !s_reg.ctrlA[0] && s_reg.ctrlA[7];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_oe_a; compareOutputAOe == outputPinDirectionBitA; endproperty
    a_oe_a: assert property (p_oe_a) else $error("pin a enable wrong");
    property p_oe_b; compareOutputBOe == outputPinDirectionBitB; endproperty
    a_oe_b: assert property (p_oe_b) else $error("pin b enable wrong");
    property p_mux_a; s_reg.ctrlA[7:6] == 2'h0 |-> compareOutputA == portDataA; endproperty
    a_mux_a: assert property (p_mux_a) else $error("pin a not port");
    property p_mux_b; s_reg.ctrlA[5:4] == 2'h0 |-> compareOutputB == portDataB; endproperty
    a_mux_b: assert property (p_mux_b) else $error("pin b not port");
    property p_rd_idle; !$past(regRead) |-> regRdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_cnt_wr;
        regWrite && regAddr == ADDR_COUNTER ##1 regRead && regAddr == ADDR_COUNTER
        |=> regRdata == $past(regWdata, 2);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");
    property p_irq_en; !s_reg.ovfEn |-> !irqOverflow; endproperty
    a_irq_en: assert property (p_irq_en) else $error("masked request seen");
    property p_force; forceA |-> ##3 compareOutputA == $past(s_reg.ctrlA[6], 3); endproperty
    a_force: assert property (p_force) else $error("force not applied");
    c_force: cover property (forceA);
    c_irq: cover property ($rose(irqOverflow));
    c_cnt: cover property (p_cnt_wr);
endmodule : ebtcp_timer_chk
bind ebtcp_timer ebtcp_timer_chk i_ebtcp_timer_chk (.*);

// ---- ebtcp_timer_tb_top.sv ----
// self-checking bench of the eight-bit compare/pwm timer
`timescale 1ns/100ps
module ebtcp_timer_tb_top import ebtcp_pkg::*;;
    typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] q;} ebtcp_row_t;
    localparam ebtcp_row_t ROWS [6] = '{'{ADDR_CTRL_A, 8'hff, 8'hf3},
        '{ADDR_CTRL_B, 8'h7f, 8'h0f}, '{ADDR_CMP_A, 8'h5a, 8'h5a},
        '{ADDR_CMP_B, 8'ha5, 8'ha5}, '{ADDR_INT_EN, 8'h07, 8'h07}, '{ADDR_ASYNC, 8'h01, 8'h01}};
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic [DATA_W-1:0] regRdata;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic irqOverflow, irqCompareA, irqCompareB, oscillatorPinTwo;
    logic ackOverflow = 1'b0;
    logic portDataB = 1'b0;
    logic dirA = 1'b0;
    logic outA, oeA, outB, oeB;
    logic [7:0] d;
    logic [15:0] n;
    int error_cnt = 0;
    int n_compared = 0;
    ebtcp_timer i_ebtcp_timer (.*, .ackCompareA(1'b0), .ackCompareB(1'b0),
        .oscillatorPinOne(1'b0), .portDataA(1'b0), .outputPinDirectionBitA(dirA),
        .compareOutputA(outA), .compareOutputAOe(oeA), .outputPinDirectionBitB(1'b1),
        .compareOutputB(outB), .compareOutputBOe(oeB));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    // cycles until pin a changes
    task automatic gap();
        logic last;
        last = outA;
        n = 0;
        while (outA === last) begin
            if (n == 16'd600) begin
                error_cnt++;
                end_of_test();
            end
            @(posedge clk_sys);
            #1 n++;
        end
    endtask : gap
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(3'(i));
            chk(d, 8'h00);
        end
        foreach (ROWS[i]) begin
            wr(ROWS[i].a, ROWS[i].d);
            rd(ROWS[i].a);
            chk(d, ROWS[i].q);
        end
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_ASYNC, 8'h00);
        wr(ADDR_FLAGS, 8'h07);
        wr(ADDR_COUNTER, 8'h10);
        portDataB <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rd(ADDR_COUNTER);
        chk(d, 8'h10);
        chk(8'({outB, oscillatorPinTwo}), 8'h03);
        $display("test stopped counter done");
        wr(ADDR_CTRL_A, 8'hc0);
        wr(ADDR_CTRL_B, 8'h80);
        repeat (3) @(posedge clk_sys);
        #1 chk(8'({outA, oeA}), 8'h02);
        dirA <= 1'b1;
        wr(ADDR_CTRL_A, 8'h80);
        wr(ADDR_CTRL_B, 8'h80);
        repeat (3) @(posedge clk_sys);
        #1 chk(8'({outA, oeA}), 8'h01);
        $display("test force done");
        wr(ADDR_CMP_A, 8'hfe);
        wr(ADDR_CMP_B, 8'h80);
        wr(ADDR_INT_EN, 8'h03);
        wr(ADDR_COUNTER, 8'hfd);
        wr(ADDR_CTRL_B, 8'h01);
        repeat (5) @(posedge clk_sys);
        #1 chk(8'({irqCompareA, irqOverflow}), 8'h03);
        rd(ADDR_FLAGS);
        chk(d, 8'h03);
        wr(ADDR_COUNTER, 8'h20);
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        ackOverflow <= 1'b1;
        #1 chk(regRdata, 8'h20);
        @(posedge clk_sys);
        ackOverflow <= 1'b0;
        #1 chk(8'(irqOverflow), 8'h00);
        wr(ADDR_FLAGS, 8'h02);
        rd(ADDR_FLAGS);
        chk(d, 8'h00);
        $display("test overflow done");
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_COUNTER, 8'h00);
        wr(ADDR_CMP_A, 8'h03);
        wr(ADDR_CTRL_A, 8'h42);
        wr(ADDR_CTRL_B, 8'h01);
        gap();
        gap();
        chk(8'(n), 8'd4);
        rd(ADDR_FLAGS);
        chk(8'(d[0]), 8'h00);
        $display("test clear on match done");
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_CMP_A, 8'h40);
        wr(ADDR_FLAGS, 8'h07);
        wr(ADDR_CTRL_A, 8'h83);
        wr(ADDR_CTRL_B, 8'h01);
        gap();
        if (outA !== 1'b1)
            gap();
        gap();
        chk(8'(n), 8'd65);
        gap();
        chk(8'(n), 8'd191);
        rd(ADDR_FLAGS);
        chk(8'(d[0]), 8'h01);
        $display("test fast pwm done");
        end_of_test();
    end
endmodule : ebtcp_timer_tb_top
